// file: src/ssf_map.svh
// register offsets, field positions and reset values of the status flag block
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH

// ***************************************************
// offsets from the programmed i/o base
// ***************************************************
`define SSF_OFS_HOST_STS 16'h0000
`define SSF_OFS_SLAVE_STS 16'h0001

// ***************************************************
// host status field positions
// ***************************************************
`define SSF_HB_BUSY 0
`define SSF_HB_COMPLETION 1
`define SSF_HB_DEVERR 2
`define SSF_HB_COLLISION 3
`define SSF_HB_FAILED 4

// ***************************************************
// slave status field positions
// ***************************************************
`define SSF_SB_BUSY 0
`define SSF_SB_SLVEVT 2
`define SSF_SB_SHADOW1 3
`define SSF_SB_SHADOW2 4
`define SSF_SB_ALERT 5

// ***************************************************
// reset values and writable-one-to-clear masks
// ***************************************************
`define SSF_RST_HOST_STS 8'h00
`define SSF_RST_SLAVE_STS 8'h00
`define SSF_W1C_HOST 8'h1e
`define SSF_W1C_SLAVE 8'h3c

// ***************************************************
// crossing layout: link events and busy levels
// ***************************************************
`define SSF_EV_DONE 0
`define SSF_EV_DEVERR 1
`define SSF_EV_COLL 2
`define SSF_EV_SHADOW1 3
`define SSF_EV_SHADOW2 4
`define SSF_EV_SLVCYC 5
`define SSF_NUM_EV 6
`define SSF_LV_HOST 6
`define SSF_LV_SLAVE 7
`define SSF_NUM_XING 8

`endif

// file: src/ssf_pkg.sv
// types shared by the status flag block
package ssf_pkg;
    typedef logic [7:0] ssf_byte_t;
    typedef logic [15:0] ssf_ioaddr_t;
    // which status register an access selects
    typedef enum logic [1:0] {
        SSF_SEL_NONE,
        SSF_SEL_HOST,
        SSF_SEL_SLAVE
    } ssf_sel_t;
endpackage

// file: src/ssf_xing_if.sv
// carrier between the link-clock end and the register end of the block
`include "ssf_map.svh"
interface ssf_xing_if;
    logic [`SSF_NUM_XING-1:0] xingBits; // event toggles and busy levels
    logic [7:0] rxCommand;              // held until the next slave cycle toggle
    logic [7:0] rxData;
    logic abortToggle;                  // register side to link side
    modport link (
        output xingBits,
        output rxCommand,
        output rxData,
        input abortToggle
    );
    modport core (
        input xingBits,
        input rxCommand,
        input rxData,
        output abortToggle
    );
endinterface

// file: src/ssf_bit_sync.sv
// two-flop synchroniser bank with toggle-to-pulse detection
module ssf_bit_sync #(
    parameter int W = 1
) (
    // clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // crossing bits
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] levelOut,
    output logic [W-1:0] changePulse
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // a frozen clock enable holds toggles, so no event is lost
    assign levelOut = sync_q;
    assign changePulse = ce ? (sync_q ^ prev_q) : '0;
endmodule

// file: src/ssf_link_side.sv
// link-clock end: turns engine events into toggles and receives aborts
`include "ssf_map.svh"
module ssf_link_side (
    // link clock domain
    input wire logic linkClk,
    input wire logic linkSrst,
    // protocol engine events, one-cycle pulses on linkClk, and received bytes
    input wire logic engDone,
    input wire logic engDevErr,
    input wire logic engCollision,
    input wire logic engShadow1,
    input wire logic engShadow2,
    input wire logic engSlaveCycle,
    input wire logic [7:0] engRxCommand,
    input wire logic [7:0] engRxData,
    // engine activity levels
    input wire logic engHostActive,
    input wire logic engSlaveActive,
    // abort pulse to the engine
    output logic engAbort,
    // crossing
    ssf_xing_if.link xing
);
    logic [`SSF_NUM_EV-1:0] evTog_q;
    logic [`SSF_NUM_EV-1:0] evIn;
    logic [7:0] rxCmd_q;
    logic [7:0] rxDat_q;
    logic [1:0] busy_q;
    logic abortPulse;

    assign evIn = {engSlaveCycle, engShadow2, engShadow1, engCollision, engDevErr, engDone};

    // each event flips its toggle; one crossing per event
    always_ff @(posedge linkClk) begin
        if (linkSrst) begin
            evTog_q <= '0;
        end else begin
            evTog_q <= evTog_q ^ evIn;
        end
    end

    // received bytes held stable across the slave cycle toggle crossing
    always_ff @(posedge linkClk) begin
        if (linkSrst) begin
            rxCmd_q <= 8'h00;
            rxDat_q <= 8'h00;
        end else if (engSlaveCycle) begin
            rxCmd_q <= engRxCommand;
            rxDat_q <= engRxData;
        end
    end

    // busy levels registered before they cross
    always_ff @(posedge linkClk) begin
        if (linkSrst) begin
            busy_q <= 2'b00;
        end else begin
            busy_q <= {engSlaveActive, engHostActive};
        end
    end

    assign xing.xingBits = {busy_q, evTog_q};
    assign xing.rxCommand = rxCmd_q;
    assign xing.rxData = rxDat_q;

    // abort request arrives as a toggle from the register side
    ssf_bit_sync #(.W(1)) uAbortSync (
        .clk(linkClk),
        .srst(linkSrst),
        .ce(1'b1),
        .asyncIn(xing.abortToggle),
        .levelOut(),
        .changePulse(abortPulse)
    );

    assign engAbort = abortPulse;
endmodule

// file: src/ssf_status_top.sv
// host and slave status registers of the bus controller, i/o mapped
`include "ssf_map.svh"

module ssf_status_top (
    // register clock domain
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // i/o access port
    input wire ssf_pkg::ssf_ioaddr_t ioBase,
    input wire ssf_pkg::ssf_ioaddr_t ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire ssf_pkg::ssf_byte_t ioWrData,
    output ssf_pkg::ssf_byte_t ioRdData,
    output logic ioRdValid,
    // loose control bits
    input wire logic abortReq,
    input wire logic completionIrqEnable,
    input wire logic alertEnable,
    input wire ssf_pkg::ssf_byte_t slaveCommandMatch,
    input wire ssf_pkg::ssf_byte_t slaveDataEventMatch,
    input wire logic smbAlertN,
    output logic hostIrq,
    // link clock domain and protocol engine
    input wire logic linkClk,
    input wire logic linkSrst,
    input wire logic engDone,
    input wire logic engDevErr,
    input wire logic engCollision,
    input wire logic engShadow1,
    input wire logic engShadow2,
    input wire logic engSlaveCycle,
    input wire ssf_pkg::ssf_byte_t engRxCommand,
    input wire ssf_pkg::ssf_byte_t engRxData,
    input wire logic engHostActive,
    input wire logic engSlaveActive,
    output logic engAbort
);
    import ssf_pkg::*;

    // ***************************************************
    // helpers
    // ***************************************************
    // set wins over a simultaneous write-one clear
    function automatic ssf_byte_t w1c_next(ssf_byte_t cur, ssf_byte_t clr, ssf_byte_t set,
                                           ssf_byte_t mask);
        w1c_next = ((cur & ~clr) | set) & mask;
    endfunction

    // ***************************************************
    // crossing from the link clock
    // ***************************************************
    ssf_xing_if xing ();

    ssf_link_side uLink (
        .linkClk(linkClk),
        .linkSrst(linkSrst),
        .engDone(engDone),
        .engDevErr(engDevErr),
        .engCollision(engCollision),
        .engShadow1(engShadow1),
        .engShadow2(engShadow2),
        .engSlaveCycle(engSlaveCycle),
        .engRxCommand(engRxCommand),
        .engRxData(engRxData),
        .engHostActive(engHostActive),
        .engSlaveActive(engSlaveActive),
        .engAbort(engAbort),
        .xing(xing.link)
    );

    logic [`SSF_NUM_XING-1:0] xLevel;
    logic [`SSF_NUM_XING-1:0] xPulse;

    ssf_bit_sync #(.W(`SSF_NUM_XING)) uXingSync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .asyncIn(xing.xingBits),
        .levelOut(xLevel),
        .changePulse(xPulse)
    );

    // alert pin is asynchronous: two flops before any use
    logic [0:0] alertSync;
    ssf_bit_sync #(.W(1)) uAlertSync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .asyncIn(~smbAlertN),
        .levelOut(alertSync),
        .changePulse()
    );

    logic hostBusy;
    logic slaveBusy;
    assign hostBusy = xLevel[`SSF_LV_HOST];
    assign slaveBusy = xLevel[`SSF_LV_SLAVE];

    // ***************************************************
    // address decode
    // ***************************************************
    ssf_sel_t sel;
    always_comb begin
        if (ioAddr == ioBase + `SSF_OFS_HOST_STS) begin
            sel = SSF_SEL_HOST;
        end else if (ioAddr == ioBase + `SSF_OFS_SLAVE_STS) begin
            sel = SSF_SEL_SLAVE;
        end else begin
            sel = SSF_SEL_NONE;
        end
    end

    logic wrHost;
    logic wrSlave;
    assign wrHost = ioWrite && (sel == SSF_SEL_HOST);
    assign wrSlave = ioWrite && (sel == SSF_SEL_SLAVE);

    // ***************************************************
    // abort request and its crossing to the engine
    // ***************************************************
    logic abortPrev_q;
    logic abortRise;
    logic abortTog_q;

    // edge of the abort bit, same clock so no synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            abortPrev_q <= 1'b0;
        end else if (ce) begin
            abortPrev_q <= abortReq;
        end
    end
    assign abortRise = ce && abortReq && !abortPrev_q;

    // toggle carries the stop to the engine on its own clock
    always_ff @(posedge clk) begin
        if (srst) begin
            abortTog_q <= 1'b0;
        end else if (abortRise) begin
            abortTog_q <= ~abortTog_q;
        end
    end
    assign xing.abortToggle = abortTog_q;

    // ***************************************************
    // host status flags
    // ***************************************************
    ssf_byte_t hostSts_q;
    ssf_byte_t hostSet;
    ssf_byte_t hostClr;

    always_comb begin
        hostSet = 8'h00;
        hostSet[`SSF_HB_FAILED] = abortRise;
        hostSet[`SSF_HB_COLLISION] = xPulse[`SSF_EV_COLL];
        hostSet[`SSF_HB_DEVERR] = xPulse[`SSF_EV_DEVERR];
        hostSet[`SSF_HB_COMPLETION] = xPulse[`SSF_EV_DONE];
    end
    assign hostClr = wrHost ? ioWrData : 8'h00;

    // sticky flags, reserved bits masked away
    always_ff @(posedge clk) begin
        if (srst) begin
            hostSts_q <= `SSF_RST_HOST_STS;
        end else if (ce) begin
            hostSts_q <= w1c_next(hostSts_q, hostClr, hostSet, `SSF_W1C_HOST);
        end
    end

    // ***************************************************
    // slave status flags
    // ***************************************************
    ssf_byte_t slvSts_q;
    ssf_byte_t slvSet;
    ssf_byte_t slvClr;
    logic slvMatch;

    // compare uses bytes held stable by the link end
    assign slvMatch = (xing.rxCommand == slaveCommandMatch)
                   && (xing.rxData == slaveDataEventMatch);

    always_comb begin
        slvSet = 8'h00;
        slvSet[`SSF_SB_ALERT] = ce && alertSync[0] && alertEnable;
        slvSet[`SSF_SB_SHADOW2] = xPulse[`SSF_EV_SHADOW2];
        slvSet[`SSF_SB_SHADOW1] = xPulse[`SSF_EV_SHADOW1];
        slvSet[`SSF_SB_SLVEVT] = xPulse[`SSF_EV_SLVCYC] && slvMatch;
    end
    assign slvClr = wrSlave ? ioWrData : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            slvSts_q <= `SSF_RST_SLAVE_STS;
        end else if (ce) begin
            slvSts_q <= w1c_next(slvSts_q, slvClr, slvSet, `SSF_W1C_SLAVE);
        end
    end

    // ***************************************************
    // read path
    // ***************************************************
    ssf_byte_t rdMux;
    always_comb begin
        case (sel)
            SSF_SEL_HOST: rdMux = hostSts_q | {7'h00, hostBusy};
            SSF_SEL_SLAVE: rdMux = slvSts_q | {7'h00, slaveBusy};
            default: rdMux = 8'hff; // unmapped reads float high like an idle bus
        endcase
    end

    // data registered one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            ioRdData <= 8'h00;
            ioRdValid <= 1'b0;
        end else if (ce) begin
            ioRdValid <= ioRead && (sel != SSF_SEL_NONE);
            if (ioRead) begin
                ioRdData <= rdMux;
            end
        end
    end

    // ***************************************************
    // interrupt
    // ***************************************************
    // failed always interrupts; completion only when enabled
    always_ff @(posedge clk) begin
        if (srst) begin
            hostIrq <= 1'b0;
        end else if (ce) begin
            hostIrq <= hostSts_q[`SSF_HB_FAILED]
                    || (hostSts_q[`SSF_HB_COMPLETION] && completionIrqEnable);
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    a_failed_on_abort: assert property (@(posedge clk) disable iff (srst)
        abortRise |=> hostSts_q[`SSF_HB_FAILED])
        else $error("failed flag not set after abort");

    a_collision_sets: assert property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_COLL] |=> hostSts_q[`SSF_HB_COLLISION])
        else $error("collision flag not set");

    a_deverr_sets: assert property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_DEVERR] |=> hostSts_q[`SSF_HB_DEVERR])
        else $error("device error flag not set");

    a_completion_sets: assert property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_DONE] |=> hostSts_q[`SSF_HB_COMPLETION])
        else $error("completion flag not set");

    a_w1c_clears: assert property (@(posedge clk) disable iff (srst)
        (ce && wrHost && ioWrData[`SSF_HB_COMPLETION] && !xPulse[`SSF_EV_DONE])
        |=> !hostSts_q[`SSF_HB_COMPLETION])
        else $error("write one did not clear completion");

    a_zero_keeps: assert property (@(posedge clk) disable iff (srst)
        (ce && wrSlave && !ioWrData[`SSF_SB_SHADOW1] && slvSts_q[`SSF_SB_SHADOW1])
        |=> slvSts_q[`SSF_SB_SHADOW1])
        else $error("write zero disturbed a flag");

    a_busy_read: assert property (@(posedge clk) disable iff (srst)
        (ce && ioRead && sel == SSF_SEL_HOST) |=> ioRdData[0] == $past(hostBusy))
        else $error("host busy misread");

    a_alert_gated: assert property (@(posedge clk) disable iff (srst)
        $rose(slvSts_q[`SSF_SB_ALERT]) |-> $past(alertEnable) && $past(alertSync[0]))
        else $error("alert flag set while disabled");

    a_shadow2_sets: assert property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_SHADOW2] |=> slvSts_q[`SSF_SB_SHADOW2])
        else $error("second shadow flag not set");

    a_shadow1_sets: assert property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_SHADOW1] |=> slvSts_q[`SSF_SB_SHADOW1])
        else $error("first shadow flag not set");

    a_slave_match: assert property (@(posedge clk) disable iff (srst)
        $rose(slvSts_q[`SSF_SB_SLVEVT]) |-> $past(xPulse[`SSF_EV_SLVCYC]) && $past(slvMatch))
        else $error("slave event flag without a match");

    a_slvbusy_read: assert property (@(posedge clk) disable iff (srst)
        (ce && ioRead && sel == SSF_SEL_SLAVE) |=> ioRdData[0] == $past(slaveBusy))
        else $error("slave busy misread");

    a_decode_valid: assert property (@(posedge clk) disable iff (srst)
        (ce && ioRead && ioAddr == ioBase + `SSF_OFS_SLAVE_STS) |=> ioRdValid)
        else $error("slave status not decoded at base plus one");

    a_irq_gated: assert property (@(posedge clk) disable iff (srst)
        (ce && !completionIrqEnable && !hostSts_q[`SSF_HB_FAILED]) |=> !hostIrq)
        else $error("interrupt without enable");

    a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
        (hostSts_q[7:5] == 3'h0) && (slvSts_q[7:6] == 2'h0) && !slvSts_q[1])
        else $error("reserved bit set");

    a_reset_zero: assert property (@(posedge clk)
        srst |=> (hostSts_q == 8'h00) && (slvSts_q == 8'h00) && !hostIrq)
        else $error("status not cleared by reset");

    c_abort_seen: cover property (@(posedge clk) disable iff (srst)
        abortRise && hostBusy ##[1:20] !hostBusy);
    c_set_and_clear: cover property (@(posedge clk) disable iff (srst)
        xPulse[`SSF_EV_DONE] && wrHost && ioWrData[`SSF_HB_COMPLETION]);
    c_slave_event: cover property (@(posedge clk) disable iff (srst)
        $rose(slvSts_q[`SSF_SB_SLVEVT]));
    c_irq_raised: cover property (@(posedge clk) disable iff (srst) $rose(hostIrq));
endmodule

// file: testbench/ssf_engine_model.sv
// behavioural protocol engine: event pulses, slave bytes and activity levels
module ssf_engine_model (
    // link clock and stop request from the block
    input wire logic linkClk,
    input wire logic engAbort,
    // events, received bytes and activity
    output logic [5:0] ev,
    output logic [7:0] rxCommand,
    output logic [7:0] rxData,
    output logic hostActive,
    output logic slaveActive
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ev = 6'h00;
        rxCommand = 8'h00;
        rxData = 8'h00;
        hostActive = 1'b0;
        slaveActive = 1'b0;
    end
    // one-cycle pulse; bytes are scrambled afterwards so nothing stale can be relied on
    task automatic fire(input int idx, input logic [7:0] cmd, input logic [7:0] dat);
        @(posedge linkClk);
        ev[idx] <= 1'b1;
        rxCommand <= cmd;
        rxData <= dat;
        @(posedge linkClk);
        ev[idx] <= 1'b0;
        rxCommand <= ~cmd;
        rxData <= ~dat;
    endtask
    // activity levels change on the link clock only
    task automatic level(input logic h, input logic s);
        @(posedge linkClk);
        hostActive <= h;
        slaveActive <= s;
    endtask
    // a stop request ends the host transaction at once
    always @(posedge linkClk) begin
        if (engAbort) hostActive <= 1'b0;
    end
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the status flag block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssf_pkg::*;
    localparam ssf_ioaddr_t BASE = 16'h0c40;
    logic clk = 1'b0, linkClk = 1'b0, srst = 1'b1, ioWrite = 1'b0, ioRead = 1'b0;
    logic abortReq = 1'b0, irqEn = 1'b0, alertEn = 1'b0, alertN = 1'b1, ce = 1'b1;
    logic ioRdValid, hostIrq, engAbort, hostAct, slvAct;
    ssf_ioaddr_t ioAddr = 16'h0000;
    ssf_byte_t ioWrData = 8'h00, cmdMatch = 8'h5a, datMatch = 8'hc3, ioRdData, rxCmd, rxDat;
    logic [5:0] ev;
    int fails = 0, cmpCount = 0, cycles = 0;

    // ***************************************************
    // clocks, design and engine model
    // ***************************************************
    initial forever #50 clk = ~clk;
    initial begin
        #3;
        forever #7.5 linkClk = ~linkClk;
    end
    ssf_status_top DUT (.clk(clk), .srst(srst), .ce(ce), .ioBase(BASE), .ioAddr(ioAddr),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .ioRdValid(ioRdValid), .abortReq(abortReq), .completionIrqEnable(irqEn),
        .alertEnable(alertEn), .slaveCommandMatch(cmdMatch), .slaveDataEventMatch(datMatch),
        .smbAlertN(alertN), .hostIrq(hostIrq), .linkClk(linkClk), .linkSrst(srst),
        .engDone(ev[0]), .engDevErr(ev[1]), .engCollision(ev[2]), .engShadow1(ev[3]),
        .engShadow2(ev[4]), .engSlaveCycle(ev[5]), .engRxCommand(rxCmd), .engRxData(rxDat),
        .engHostActive(hostAct), .engSlaveActive(slvAct), .engAbort(engAbort));
    ssf_engine_model ENG (.linkClk(linkClk), .engAbort(engAbort), .ev(ev), .rxCommand(rxCmd),
        .rxData(rxDat), .hostActive(hostAct), .slaveActive(slvAct));

    // ***************************************************
    // access and compare tasks
    // ***************************************************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // strobe is one cycle wide; the answer is registered by the taking edge
    task automatic ioRd(input logic [15:0] ofs, output logic [7:0] d, output logic v);
        @(negedge clk);
        ioAddr = BASE + ofs;
        ioRead = 1'b1;
        @(negedge clk);
        ioRead = 1'b0;
        d = ioRdData;
        v = ioRdValid;
    endtask
    task automatic ioWr(input logic [15:0] ofs, input logic [7:0] d);
        @(negedge clk);
        ioAddr = BASE + ofs;
        ioWrData = d;
        ioWrite = 1'b1;
        @(negedge clk);
        ioWrite = 1'b0;
    endtask
    task automatic rdChk(input string what, input logic [15:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        ioRd(ofs, d, v);
        chk(what, d, exp);
    endtask
    task automatic irqChk(input string what, input logic exp);
        chk(what, {7'h00, hostIrq}, {7'h00, exp});
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic tReset;
        logic [7:0] d;
        logic v;
        ioRd(16'h0000, d, v);
        chk("host_rst", d, 8'h00);
        chk("host_valid", {7'h00, v}, 8'h01);
        ioRd(16'h0001, d, v);
        chk("slave_rst", d, 8'h00);
        ioRd(16'h0002, d, v);
        chk("unmapped_valid", {7'h00, v}, 8'h00);
        chk("unmapped_data", d, 8'hff);
    endtask
    // completion, device error and collision, one after another
    task automatic tHostEvents;
        for (int i = 0; i < 3; i++) begin
            ENG.fire(i, 8'h00, 8'h00);
            waitClk(8);
            rdChk("host_event", 0, 8'h02 << i);
            ioWr(0, 8'hff ^ (8'h02 << i));
            rdChk("host_keep", 0, 8'h02 << i);
            ioWr(0, 8'h02 << i);
            rdChk("host_clear", 0, 8'h00);
        end
    endtask
    task automatic tIrq;
        ENG.fire(0, 8'h00, 8'h00);
        waitClk(8);
        irqChk("irq_masked", 1'b0);
        irqEn = 1'b1;
        waitClk(3);
        irqChk("irq_enabled", 1'b1);
        // a write taken while the clock enable is low must not clear anything
        ce = 1'b0;
        ioWr(0, 8'h02);
        ce = 1'b1;
        rdChk("ce_frozen", 0, 8'h02);
        irqChk("irq_frozen", 1'b1);
        ioWr(0, 8'h02);
        waitClk(2);
        irqChk("irq_cleared", 1'b0);
        irqEn = 1'b0;
    endtask
    // only the host status register itself is touched while busy
    task automatic tAbort;
        ENG.level(1'b1, 1'b0);
        waitClk(6);
        rdChk("host_busy", 0, 8'h01);
        ioWr(0, 8'h01);
        rdChk("busy_ro", 0, 8'h01);
        abortReq = 1'b1;
        waitClk(8);
        rdChk("host_failed", 0, 8'h10);
        irqChk("irq_failed", 1'b1);
        abortReq = 1'b0;
        ioWr(0, 8'h10);
        waitClk(2);
        rdChk("failed_clear", 0, 8'h00);
        irqChk("irq_idle", 1'b0);
    endtask
    // slave busy is raised last so no other register is touched meanwhile
    task automatic tSlave;
        ENG.fire(3, 8'h00, 8'h00);
        waitClk(8);
        rdChk("shadow1", 1, 8'h08);
        ENG.fire(4, 8'h00, 8'h00);
        waitClk(8);
        rdChk("shadow2", 1, 8'h18);
        ENG.fire(5, 8'h5a, 8'h00);
        waitClk(8);
        rdChk("event_miss", 1, 8'h18);
        ENG.fire(5, 8'h00, 8'hc3);
        waitClk(8);
        rdChk("event_cmd_miss", 1, 8'h18);
        ENG.fire(5, 8'h5a, 8'hc3);
        waitClk(8);
        rdChk("event_hit", 1, 8'h1c);
        ioWr(1, 8'h18);
        rdChk("slave_w1c", 1, 8'h04);
        ioWr(1, 8'hff);
        rdChk("slave_clear", 1, 8'h00);
        alertN = 1'b0;
        waitClk(6);
        rdChk("alert_off", 1, 8'h00);
        alertEn = 1'b1;
        waitClk(6);
        rdChk("alert_on", 1, 8'h20);
        alertN = 1'b1;
        alertEn = 1'b0;
        waitClk(4);
        ioWr(1, 8'h20);
        rdChk("alert_clear", 1, 8'h00);
        ENG.level(1'b0, 1'b1);
        waitClk(6);
        rdChk("slave_busy", 1, 8'h01);
        ENG.level(1'b0, 1'b0);
        waitClk(6);
        rdChk("slave_idle", 1, 8'h00);
    endtask

    // main sequence; the run needs a few hundred cycles
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        tReset;
        tHostEvents;
        tIrq;
        tAbort;
        tSlave;
        wrap_up;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            wrap_up;
        end
    end
endmodule
